// ==== logic/scm_core.sv ====
// Purpose: System clock selection, fast oscillator control and power modes.
// Assumes: AXI4-Lite slave on aclk; clocks leave as one-cycle enable ticks.
// Notes: A tick based clock tree cannot emit a truncated pulse by construction.
//
// How it works
// - Fast oscillator runs at 2, 4 or 8 MHz
// - Slow clock comes from 32 kHz oscillator
// - FAST mode divides fast clock by 1..64
// - Keep bits never affect the running clock
// - Fast oscillator in SLOW mode follows enable
// - Halt with keeps 00 enters SLEEP
// - Watchdog slow clock always runs
// - Halt with keeps 01 enters idle slow
// - Halt with keeps 11 enters idle both
// - Halt with keeps 10 enters idle fast
// - Slow oscillator also feeds watchdog and time base
// - Select codes 000-110 divide, 111 slow
// - Stable flag clears, then sets as frequency applies
`timescale 1ns/100ps
module scm_core (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core power-down instruction and wake-up event
  input wire logic halt_req,
  input wire logic wake_req,
  // Clock enables to the consumers
  output logic cpu_clk_tick,
  output logic sys_clk_tick,
  output logic fast_clock_tick,
  output logic [6:0] fast_tap_tick,
  output logic slow_clk_tick,
  output logic watchdog_clk_tick,
  output logic fast_osc_stable_flag,
  output logic [2:0] op_mode
);
  // Software visible control state
  logic [2:0] sys_clk_select_q; // Requested system clock source
  logic fast_osc_keep_in_idle_q; // Keep fast oscillator while halted
  logic slow_osc_keep_in_idle_q; // Keep slow peripheral clock while halted
  logic [1:0] freq_sel_q; // Requested fast oscillator rate
  logic fast_osc_enable_q; // Fast oscillator enable
  logic stable_q; // Fast oscillator settled
  logic [11:0] settle_q; // Settling countdown
  logic [1:0] freq_act_q; // Rate actually applied
  logic [2:0] sel_act_q; // Source actually feeding the system clock
  scm_pkg::scm_state_type state_q; // Power state
  scm_pkg::scm_state_type state_d;
  logic fast_run_q; // Previous fast run level, for restart detect
  // Bus channel state
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  // Registered clock outputs
  logic cpu_q;
  logic sys_q;
  logic fast_q;
  logic [6:0] tap_q;
  logic slow_q;
  logic wd_q; // Watchdog and time base enable

  // Write path: address and data taken together, one at a time
  // Neither channel is taken alone, so a master offering them apart waits
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire wr_lane0 = s_axi_wstrb[0];
  wire wr_sys = wr_go && (s_axi_awaddr == scm_pkg::SYSCLK_CTRL_ADDR);
  wire wr_fast = wr_go && (s_axi_awaddr == scm_pkg::FAST_CTRL_ADDR);
  wire wr_pwr = wr_go && (s_axi_awaddr == scm_pkg::PWR_CMD_ADDR);
  wire wr_stat = wr_go && (s_axi_awaddr == scm_pkg::MODE_STAT_ADDR);
  wire wr_hit = wr_sys || wr_fast || wr_pwr || wr_stat;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read path: one read outstanding
  // A new read waits until the previous answer has been taken
  wire rd_go = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Next values of the fast oscillator control fields
  wire [1:0] freq_d = (wr_fast && wr_lane0) ? s_axi_wdata[scm_pkg::FREQ_LSB +: 2] : freq_sel_q;
  wire fen_d = (wr_fast && wr_lane0) ? s_axi_wdata[scm_pkg::FEN_BIT] : fast_osc_enable_q;

  // Power-down instruction from the core or from software
  wire halt_now = halt_req || (wr_pwr && wr_lane0 && s_axi_wdata[scm_pkg::HALT_BIT]);

  // Status decode
  wire running = (state_q == scm_pkg::ST_RUN);
  wire act_slow = (sel_act_q == scm_pkg::SEL_SLOW);
  wire req_slow = (sys_clk_select_q == scm_pkg::SEL_SLOW);
  wire idle_fast_on = (state_q == scm_pkg::ST_IDLE_BOTH_OSC) || (state_q == scm_pkg::ST_IDLE_FAST_ONLY);
  wire idle_slow_on = (state_q == scm_pkg::ST_IDLE_SLOW_ONLY) || (state_q == scm_pkg::ST_IDLE_BOTH_OSC);

  // Fast oscillator runs while it sources the CPU, by enable in SLOW mode,
  // and only by its keep bit once halted.
  // A pending switch back to a fast source also starts it: otherwise a
  // disabled oscillator could never settle and the switch would hang.
  wire fast_run = running ? (fast_osc_enable_q || !act_slow || !req_slow) : idle_fast_on;
  // Peripheral slow clock is on while running and in the two idles that keep it
  wire slow_on = running || idle_slow_on;

  // Restart settling when the oscillator starts or its rate is changed
  // Restart wins over the end of a count, so a new rate is never flagged early
  wire restart = fast_run && (!fast_run_q || (fen_d && !fast_osc_enable_q) || (freq_d != freq_sel_q));

  // Tick period for the applied rate; codes above 4 MHz select 8 MHz
  wire [11:0] fast_per = (freq_act_q == scm_pkg::FREQ_2M) ? scm_pkg::FAST_PER_2M :
                         (freq_act_q == scm_pkg::FREQ_4M) ? scm_pkg::FAST_PER_4M :
                         scm_pkg::FAST_PER_8M;

  // Oscillator models
  wire fast_raw; // Free running fast oscillator ticks
  wire slow_raw; // Slow oscillator ticks, never gated
  scm_osc_tick u_fast_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(fast_run),
    .period(fast_per),
    .tick(fast_raw)
  );
  // Slow oscillator is never stopped: the watchdog depends on it
  scm_osc_tick u_slow_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(1'b1),
    .period(scm_pkg::SLOW_PER),
    .tick(slow_raw)
  );

  // Fast clock reaches consumers only once settled.
  // A tick that meets a restart is dropped, so no fast pulse is ever
  // seen after the stable flag has gone low.
  wire fast_ok = fast_raw && stable_q && fast_run && !restart;
  wire [6:0] taps;
  scm_tap_div u_taps (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_tick(fast_ok),
    .taps(taps)
  );

  // System clock source mux: divided fast taps or slow clock
  wire sys_raw = act_slow ? slow_raw : taps[sel_act_q];
  // System clock runs when its own source is on for peripherals
  wire sys_on = act_slow ? slow_on : fast_run;
  // Peripheral slow clock: the slow oscillator gated by the power state
  wire slow_periph = slow_raw && slow_on;

  // A source change is taken only right after a tick of the current source or while that source is off,
  // and switching onto the fast side waits for a settled oscillator
  wire sel_ready = req_slow || stable_q;
  wire sel_switch = (sys_clk_select_q != sel_act_q) && sel_ready && (sys_raw || !sys_on);

  // Power state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      scm_pkg::ST_RUN: begin
        // The keep bits alone pick which halted state is entered
        if (halt_now) begin
          case ({fast_osc_keep_in_idle_q, slow_osc_keep_in_idle_q})
            2'b00: state_d = scm_pkg::ST_SLEEP;
            2'b01: state_d = scm_pkg::ST_IDLE_SLOW_ONLY;
            2'b11: state_d = scm_pkg::ST_IDLE_BOTH_OSC;
            default: state_d = scm_pkg::ST_IDLE_FAST_ONLY;
          endcase
        end
      end
      scm_pkg::ST_SLEEP, scm_pkg::ST_IDLE_SLOW_ONLY, scm_pkg::ST_IDLE_BOTH_OSC, scm_pkg::ST_IDLE_FAST_ONLY: begin
        // Any wake event returns to normal operation
        if (wake_req) begin
          state_d = scm_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = scm_pkg::ST_RUN;
      end
    endcase
  end

  // Reported operating mode
  // Halted states report themselves whatever source is selected
  always_comb begin
    case (state_q)
      scm_pkg::ST_RUN: op_mode = act_slow ? scm_pkg::MODE_SLOW : scm_pkg::MODE_FAST;
      scm_pkg::ST_SLEEP: op_mode = scm_pkg::MODE_SLEEP;
      scm_pkg::ST_IDLE_SLOW_ONLY: op_mode = scm_pkg::MODE_IDLE_SLOW_ONLY;
      scm_pkg::ST_IDLE_BOTH_OSC: op_mode = scm_pkg::MODE_IDLE_BOTH_OSC;
      scm_pkg::ST_IDLE_FAST_ONLY: op_mode = scm_pkg::MODE_IDLE_FAST_ONLY;
      default: op_mode = scm_pkg::MODE_FAST;
    endcase
  end

  // Read data decode; reserved bits read as zero
  wire rd_sys = (s_axi_araddr == scm_pkg::SYSCLK_CTRL_ADDR);
  wire rd_fast = (s_axi_araddr == scm_pkg::FAST_CTRL_ADDR);
  wire rd_pwr = (s_axi_araddr == scm_pkg::PWR_CMD_ADDR);
  wire rd_stat = (s_axi_araddr == scm_pkg::MODE_STAT_ADDR);
  wire rd_hit = rd_sys || rd_fast || rd_pwr || rd_stat;
  wire [31:0] rd_sys_val = {24'h00_0000, sys_clk_select_q, 3'h0, fast_osc_keep_in_idle_q,
                            slow_osc_keep_in_idle_q};
  wire [31:0] rd_fast_val = {28'h000_0000, freq_sel_q, stable_q, fast_osc_enable_q};
  wire [31:0] rd_stat_val = {25'h000_0000, sel_act_q, 1'b0, op_mode};
  wire [31:0] rd_val = rd_sys ? rd_sys_val : rd_fast ? rd_fast_val : rd_stat ? rd_stat_val : 32'h0000_0000;

  // Control register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_select_q <= scm_pkg::SEL_RST;
      fast_osc_keep_in_idle_q <= 1'b0;
      slow_osc_keep_in_idle_q <= 1'b0;
      freq_sel_q <= scm_pkg::FREQ_RST;
      fast_osc_enable_q <= scm_pkg::FEN_RST;
    end else begin
      // Only byte lane 0 holds implemented fields
      if (wr_sys && wr_lane0) begin
        sys_clk_select_q <= s_axi_wdata[scm_pkg::SEL_LSB +: 3];
        fast_osc_keep_in_idle_q <= s_axi_wdata[scm_pkg::KEEP_FAST_BIT];
        slow_osc_keep_in_idle_q <= s_axi_wdata[scm_pkg::KEEP_SLOW_BIT];
      end
      freq_sel_q <= freq_d;
      fast_osc_enable_q <= fen_d;
    end
  end

  // Fast oscillator settling and rate application
  // A new rate is applied only as the flag rises, never in mid-settle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable_q <= 1'b0;
      settle_q <= scm_pkg::FAST_SETTLE_CYC;
      freq_act_q <= scm_pkg::FREQ_RST;
      fast_run_q <= 1'b0;
    end else begin
      fast_run_q <= fast_run;
      if (!fast_run || restart) begin
        // Stopped or restarting: flag drops first
        stable_q <= 1'b0;
        settle_q <= scm_pkg::FAST_SETTLE_CYC;
      end else if (!stable_q) begin
        if (settle_q == 12'h001) begin
          // Settled: raise the flag and apply the new rate together
          stable_q <= 1'b1;
          freq_act_q <= freq_sel_q;
        end else begin
          settle_q <= 12'(settle_q - 12'h001);
        end
      end
    end
  end

  // Applied source and power state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_act_q <= scm_pkg::SEL_RST;
      state_q <= scm_pkg::ST_RUN;
    end else begin
      if (sel_switch) begin
        sel_act_q <= sys_clk_select_q;
      end
      state_q <= state_d;
    end
  end

  // Clock enable outputs; each is a whole one-cycle pulse or nothing
  // Registering them keeps the consumers off long combinational paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_q <= 1'b0;
      sys_q <= 1'b0;
      fast_q <= 1'b0;
      tap_q <= 7'h00;
      slow_q <= 1'b0;
      wd_q <= 1'b0;
    end else begin
      // CPU enable follows the next state, so it stops in the very cycle
      // that op_mode reports a halt and restarts with the wake
      cpu_q <= sys_raw && sys_on && (state_d == scm_pkg::ST_RUN);
      sys_q <= sys_raw && sys_on;
      fast_q <= fast_ok;
      tap_q <= taps;
      slow_q <= slow_periph;
      wd_q <= slow_raw;
    end
  end
  assign cpu_clk_tick = cpu_q;
  assign sys_clk_tick = sys_q;
  assign fast_clock_tick = fast_q;
  assign fast_tap_tick = tap_q;
  assign slow_clk_tick = slow_q;
  assign watchdog_clk_tick = wd_q;
  assign fast_osc_stable_flag = stable_q;

  // Write response channel
  // bvalid and bresp stand until the master's bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= scm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data channel
  // rvalid and rdata stand until the master's rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= scm_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// ==== logic/scm_pkg.sv ====
// Purpose: Shared constants for the system clock and operating mode block.
// Assumes: 100 MHz bus clock; oscillators are modelled as tick pulses on it.
// Notes: Register map, field layout, reset values and timing counts.
package scm_pkg;
  // Bus clock rate
  localparam int CLK_HZ = 100_000_000;
  // Fast RC oscillator rates and tick periods in bus cycles
  localparam int FAST_HZ_2M = 2_000_000;
  localparam int FAST_HZ_4M = 4_000_000;
  localparam int FAST_HZ_8M = 8_000_000;
  localparam logic [11:0] FAST_PER_2M = 12'(CLK_HZ / FAST_HZ_2M);
  localparam logic [11:0] FAST_PER_4M = 12'(CLK_HZ / FAST_HZ_4M);
  localparam logic [11:0] FAST_PER_8M = 12'(CLK_HZ / FAST_HZ_8M);
  // Slow RC oscillator rate and tick period
  localparam int SLOW_HZ = 32_000;
  localparam logic [11:0] SLOW_PER = 12'(CLK_HZ / SLOW_HZ);
  // Fast oscillator settling time, rounded up to whole cycles
  localparam int FAST_SETTLE_NS = 1000;
  localparam logic [11:0] FAST_SETTLE_CYC = 12'((FAST_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  // Register byte offsets
  localparam logic [7:0] SYSCLK_CTRL_ADDR = 8'h00;
  localparam logic [7:0] FAST_CTRL_ADDR = 8'h04;
  localparam logic [7:0] PWR_CMD_ADDR = 8'h08;
  localparam logic [7:0] MODE_STAT_ADDR = 8'h0C;
  // Field positions
  localparam int SEL_LSB = 5;
  localparam int KEEP_FAST_BIT = 1;
  localparam int KEEP_SLOW_BIT = 0;
  localparam int FREQ_LSB = 2;
  localparam int STABLE_BIT = 1;
  localparam int FEN_BIT = 0;
  localparam int HALT_BIT = 0;
  // Reset values
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [1:0] FREQ_RST = 2'h0;
  localparam logic FEN_RST = 1'b1;
  // Encodings
  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic [1:0] FREQ_2M = 2'h0;
  localparam logic [1:0] FREQ_4M = 2'h1;
  localparam logic [2:0] MODE_FAST = 3'h0;
  localparam logic [2:0] MODE_SLOW = 3'h1;
  localparam logic [2:0] MODE_SLEEP = 3'h2;
  localparam logic [2:0] MODE_IDLE_SLOW_ONLY = 3'h3;
  localparam logic [2:0] MODE_IDLE_BOTH_OSC = 3'h4;
  localparam logic [2:0] MODE_IDLE_FAST_ONLY = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Power state of the core
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_IDLE_SLOW_ONLY, ST_IDLE_BOTH_OSC,
                            ST_IDLE_FAST_ONLY} scm_state_type;
endpackage

// ==== logic/scm_osc_tick.sv ====
// Purpose: Models an RC oscillator as a one-cycle tick every period cycles.
// Assumes: period is at least 2 and stable while run is high.
// Notes: Dropping run clears the phase, so a restart never gives a short first tick.
`timescale 1ns/100ps
module scm_osc_tick (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [11:0] period,
  output logic tick
);
  logic [11:0] cnt_q; // Phase counter
  logic [11:0] cnt_d;
  logic tick_q; // Registered tick
  // Final cycle of a period; a phase left too long by a rate change ends at once
  wire last = (cnt_q >= 12'(period - 12'h001));
  assign cnt_d = (!run || last) ? 12'h000 : 12'(cnt_q + 12'h001);
  assign tick = tick_q;
  // Counter and tick register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= run && last;
    end
  end
endmodule

// ==== logic/scm_tap_div.sv ====
// Purpose: Divides the fast tick into taps of 1, 2, 4, 8, 16, 32 and 64.
// Assumes: in_tick is a one-cycle pulse.
// Notes: Every tap is a subset of in_tick pulses, so taps stay phase aligned.
`timescale 1ns/100ps
module scm_tap_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_tick,
  output logic [6:0] taps
);
  logic [5:0] cnt_q; // Running count of input ticks
  // Advance on each input tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 6'h00;
    end else if (in_tick) begin
      cnt_q <= 6'(cnt_q + 6'h01);
    end
  end
  assign taps[0] = in_tick;
  // Tap k fires when the low k count bits are all ones
  for (genvar k = 1; k < 7; k++) begin : g_tap
    assign taps[k] = in_tick && (&cnt_q[k-1:0]);
  end
endmodule

// ==== verification/scm_core_chk.sv ====
// Purpose: Timing and mode checks on the clock select block ports.
// Assumes: Ticks are one-cycle enables; op_mode encodes the power state.
// Notes: Sleep and idle clock checks skip the entry cycle, where a registered tick may still land.
`timescale 1ns/100ps
module scm_core_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic cpu_clk_tick,
  input wire logic sys_clk_tick,
  input wire logic fast_clock_tick,
  input wire logic [6:0] fast_tap_tick,
  input wire logic slow_clk_tick,
  input wire logic watchdog_clk_tick,
  input wire logic fast_osc_stable_flag,
  input wire logic [2:0] op_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since the last watchdog tick
  logic [11:0] wd_gap_q;
  // High while the CPU is switched off
  wire halted = op_mode >= scm_pkg::MODE_SLEEP;
  // Gap counter; restarts on each watchdog tick
  always_ff @(posedge aclk) begin
    if (!aresetn) wd_gap_q <= 12'h000;
    else if (watchdog_clk_tick) wd_gap_q <= 12'h000;
    else wd_gap_q <= wd_gap_q + 12'h001;
  end
  a_cpu_off_halted: assert property (halted |-> !cpu_clk_tick)
    else $error("cpu tick while halted");
  a_halt_enters_idle: assert property (halt_req && !halted |=> halted)
    else $error("halt not taken");
  a_wake_resumes: assert property (wake_req && halted |=> !halted)
    else $error("wake not taken");
  a_sleep_all_off: assert property (op_mode == scm_pkg::MODE_SLEEP && $past(op_mode) == scm_pkg::MODE_SLEEP
    |-> !(fast_clock_tick || slow_clk_tick || sys_clk_tick))
    else $error("clock running in sleep");
  a_idle_no_fast: assert property (op_mode == scm_pkg::MODE_IDLE_SLOW_ONLY
    && $past(op_mode) == scm_pkg::MODE_IDLE_SLOW_ONLY |-> !fast_clock_tick)
    else $error("fast clock in idle slow");
  a_idle_no_slow: assert property (op_mode == scm_pkg::MODE_IDLE_FAST_ONLY
    && $past(op_mode) == scm_pkg::MODE_IDLE_FAST_ONLY |-> !slow_clk_tick)
    else $error("slow clock in idle fast");
  // Gap is at most 3124 in steady state; the first tick after reset comes
  // two cycles later, as counter and output register both start from zero
  a_wd_never_stops: assert property (wd_gap_q <= 12'hc36)
    else $error("watchdog clock stopped");
  a_fast_needs_stable: assert property (fast_clock_tick |-> fast_osc_stable_flag)
    else $error("fast tick before stable");
  a_taps_aligned: assert property (|fast_tap_tick |-> fast_tap_tick[0])
    else $error("tap off the fast tick");
  a_cpu_tick_single: assert property (cpu_clk_tick |=> !cpu_clk_tick)
    else $error("cpu tick wider than one cycle");
endmodule
bind scm_core scm_core_chk u_scm_core_chk (.aclk(aclk), .aresetn(aresetn), .halt_req(halt_req),
  .wake_req(wake_req), .cpu_clk_tick(cpu_clk_tick), .sys_clk_tick(sys_clk_tick),
  .fast_clock_tick(fast_clock_tick), .fast_tap_tick(fast_tap_tick), .slow_clk_tick(slow_clk_tick),
  .watchdog_clk_tick(watchdog_clk_tick), .fast_osc_stable_flag(fast_osc_stable_flag), .op_mode(op_mode));

// ==== verification/scm_clk_consumer.sv ====
// Purpose: Stands for the CPU and peripherals, counting the clock ticks they get.
// Assumes: clr is synchronous and wins over a tick.
// Notes: 16-bit counts; windows stay far below wrap.
`timescale 1ns/100ps
module scm_clk_consumer (
  input wire logic aclk,
  input wire logic clr,
  input wire logic cpu_tick,
  input wire logic sys_tick,
  input wire logic fast_tick,
  input wire logic slow_tick,
  input wire logic wd_tick,
  output logic [15:0] cpu_n,
  output logic [15:0] sys_n,
  output logic [15:0] fast_n,
  output logic [15:0] slow_n,
  output logic [15:0] wd_n
);
  // Each consumer just counts the enables it sees
  always_ff @(posedge aclk) begin
    if (clr) begin
      {cpu_n, sys_n, fast_n, slow_n, wd_n} <= 80'h0;
    end else begin
      cpu_n <= cpu_n + 16'(cpu_tick);
      sys_n <= sys_n + 16'(sys_tick);
      fast_n <= fast_n + 16'(fast_tick);
      slow_n <= slow_n + 16'(slow_tick);
      wd_n <= wd_n + 16'(wd_tick);
    end
  end
endmodule

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for clock select and power modes.
// Assumes: AXI4-Lite master tasks; tick counts come from the consumer model.
// Notes: Counts allow one tick of slack, as window and tick phase are unrelated.
`timescale 1ns/100ps
module tb;
  logic aclk = 0, aresetn = 0, halt_req = 0, wake_req = 0, clr = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic cpu_t, sys_t, fast_t, slow_t, wd_t, stable;
  logic [6:0] taps;
  logic [2:0] op_mode;
  logic [15:0] cpu_n, sys_n, fast_n, slow_n, wd_n;
  int errors = 0, checks_done = 0, lo, hi;
  // Keep bits {fast,slow} per mode step: sleep, idle slow, idle both, idle fast
  localparam logic [7:0] KEEPS = 8'hb4;
  scm_core u_scm_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .halt_req(halt_req), .wake_req(wake_req), .cpu_clk_tick(cpu_t),
    .sys_clk_tick(sys_t), .fast_clock_tick(fast_t), .fast_tap_tick(taps), .slow_clk_tick(slow_t),
    .watchdog_clk_tick(wd_t), .fast_osc_stable_flag(stable), .op_mode(op_mode));
  scm_clk_consumer u_scm_clk_consumer (.aclk(aclk), .clr(clr), .cpu_tick(cpu_t), .sys_tick(sys_t),
    .fast_tick(fast_t), .slow_tick(slow_t), .wd_tick(wd_t), .cpu_n(cpu_n), .sys_n(sys_n),
    .fast_n(fast_n), .slow_n(slow_n), .wd_n(wd_n));
  // 100 MHz clock
  initial begin
    forever #5 aclk = ~aclk;
  end
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Exact comparison
  task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Tick count comparison within a range
  task rng(input string name, input int lo, input int hi, input logic [15:0] seen);
    checks_done++;
    if ($isunknown(seen) || seen < lo || seen > hi) begin
      errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, seen);
    end
  endtask
  // Write: address and data offered together, bready held until bvalid; only the watchdog ends a hang
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // Read: rready held until rvalid
  task rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Clear the consumer counts, then let n cycles of ticks accumulate
  task win(input int n);
    @(posedge aclk) clr <= 1;
    @(posedge aclk) clr <= 0;
    cyc(n);
    #1;
  endtask
  task report_and_stop;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog; the full run needs about 60000 cycles
  initial begin
    cyc(90000);
    errors++;
    report_and_stop;
  end
  initial begin
    cyc(8);
    aresetn <= 1;
    rdr(scm_pkg::SYSCLK_CTRL_ADDR);
    chk("select reset", 32'h0000_0000, rd);
    rdr(scm_pkg::FAST_CTRL_ADDR);
    chk("fast ctrl reset", 32'h0000_0001, rd);
    cyc(120);
    rdr(scm_pkg::FAST_CTRL_ADDR);
    chk("fast stable", 32'h0000_0003, rd);
    rdr(8'h10);
    chk("unmapped rresp", 32'(scm_pkg::RESP_SLVERR), 32'(resp));
    wr(8'h14, 32'h0000_00ff);
    chk("unmapped bresp", 32'(scm_pkg::RESP_SLVERR), 32'(resp));
    // Keep bits set while running must not slow the clock
    wr(scm_pkg::SYSCLK_CTRL_ADDR, 32'h0000_0003);
    win(1000);
    rng("cpu with keeps", 19, 21, cpu_n);
    // Every select code, slow source last
    for (int k = 0; k < 8; k++) begin
      wr(scm_pkg::SYSCLK_CTRL_ADDR, 32'(k) << scm_pkg::SEL_LSB);
      cyc(k == 7 ? 3300 : 60 << k);
      win(3200);
      lo = k == 7 ? 1 : (64 >> k) - 1;
      hi = k == 7 ? 2 : (64 >> k) + 1;
      rng("cpu ticks", lo, hi, cpu_n);
      rng("sys ticks", lo, hi, sys_n);
    end
    // In slow mode the fast oscillator follows its enable
    wr(scm_pkg::FAST_CTRL_ADDR, 32'h0000_0000);
    win(500);
    rng("fast off in slow", 0, 0, fast_n);
    rdr(scm_pkg::MODE_STAT_ADDR);
    chk("status slow", 32'h0000_0071, rd);
    wr(scm_pkg::FAST_CTRL_ADDR, 32'h0000_0001);
    rdr(scm_pkg::FAST_CTRL_ADDR);
    chk("stable cleared", 32'h0000_0001, rd);
    cyc(120);
    win(500);
    rng("fast on in slow", 9, 11, fast_n);
    // Fast oscillator rates
    wr(scm_pkg::FAST_CTRL_ADDR, 32'h0000_0005);
    cyc(150);
    win(1000);
    rng("fast 4 MHz", 39, 41, fast_n);
    wr(scm_pkg::FAST_CTRL_ADDR, 32'h0000_0009);
    cyc(150);
    win(1000);
    rng("fast 8 MHz", 82, 84, fast_n);
    wr(scm_pkg::FAST_CTRL_ADDR, 32'h0000_0001);
    wr(scm_pkg::SYSCLK_CTRL_ADDR, 32'h0000_0000);
    cyc(3300);
    // Power-down with each keep pair; the first by register command
    for (int i = 0; i < 4; i++) begin
      wr(scm_pkg::SYSCLK_CTRL_ADDR, 32'(KEEPS[2*i +: 2]));
      if (i == 0) begin
        wr(scm_pkg::PWR_CMD_ADDR, 32'h0000_0001);
      end else begin
        @(posedge aclk) halt_req <= 1;
        @(posedge aclk) halt_req <= 0;
      end
      cyc(2);
      chk("mode", 32'(scm_pkg::MODE_SLEEP) + i, 32'(op_mode));
      win(3300);
      rng("cpu halted", 0, 0, cpu_n);
      rng("fast idle", i >= 2 ? 65 : 0, i >= 2 ? 67 : 0, fast_n);
      rng("sys idle", i >= 2 ? 65 : 0, i >= 2 ? 67 : 0, sys_n);
      rng("slow idle", i == 1 || i == 2 ? 1 : 0, i == 1 || i == 2 ? 2 : 0, slow_n);
      rng("watchdog clock", 1, 2, wd_n);
      @(posedge aclk) wake_req <= 1;
      @(posedge aclk) wake_req <= 0;
      cyc(120);
      chk("mode after wake", 32'(scm_pkg::MODE_FAST), 32'(op_mode));
    end
    report_and_stop;
  end
endmodule
